// [core/iad_pkg.sv]
package iad_pkg;
  localparam int ADDR_W = 32;               // system address width
  localparam int DATA_W = 8;                // system data width
  localparam int OFF_W  = 22;               // widest window offset (4MB)
  localparam int CFG_OFF_W = 3;             // configuration offset width

  // address spaces on the system bus
  typedef enum logic [1:0] {
    SP_CFG = 2'b00,
    SP_IO  = 2'b01,
    SP_MEM = 2'b10
  } iad_space_e;

  // display operating modes, set by the display side
  typedef enum logic [1:0] {
    DM_LEGACY   = 2'b00,
    DM_TEXT132  = 2'b01,
    DM_EXTENDED = 2'b10
  } iad_mode_e;

  // decoded targets handed to the user side
  typedef enum logic [2:0] {
    TG_NONE    = 3'b000,
    TG_IOBANK  = 3'b001,
    TG_ROM     = 3'b010,
    TG_COP     = 3'b011,
    TG_VMEM    = 3'b100,
    TG_SMALL   = 3'b101,
    TG_LEG_MEM = 3'b110,
    TG_LEG_IO  = 3'b111
  } iad_target_e;

  // configuration register offsets
  localparam logic [2:0] CFG_ID_LO = 3'h0;
  localparam logic [2:0] CFG_ID_HI = 3'h1;
  localparam logic [2:0] CFG_POS2  = 3'h2;
  localparam logic [2:0] CFG_POS4  = 3'h4;
  localparam logic [2:0] CFG_POS5  = 3'h5;

  // field positions
  localparam int ROM_MSB = 7;
  localparam int ROM_LSB = 4;
  localparam int ISEL_MSB = 3;
  localparam int ISEL_LSB = 1;
  localparam int EN_BIT = 0;
  localparam int VBASE_MSB = 7;
  localparam int VBASE_LSB = 1;
  localparam int LAE_BIT = 0;
  localparam int SAB_MSB = 3;
  localparam int SAB_LSB = 0;
  localparam logic [7:0] POS5_DEFINED = 8'h0F;  // upper nibble undefined

  // window placement
  localparam logic [31:0] IO_BANK_BASE    = 32'h0000_2100;
  localparam int          IO_BANK_LG2     = 4;   // 16 registers
  localparam logic [31:0] ROM_REGION_BASE = 32'h000C_0000;
  localparam int          ROM_BLOCK_LG2   = 13;  // 8KB blocks
  localparam logic [31:0] COP_AREA_OFF    = 32'h0000_1C00;
  localparam int          COP_LG2         = 7;   // 128-byte sections
  localparam int          ROM_KB_LSB      = 10;  // 1KB slice index
  localparam logic [2:0]  COP_KB_SLICE    = 3'h7;
  localparam int          VMEM_LG2        = 22;  // 4MB aperture
  localparam int          SMALL_LG2       = 20;  // 1MB aperture
  localparam logic [31:0] LEG_MEM_BASE    = 32'h000A_0000;
  localparam int          LEG_MEM_LG2     = 17;
  localparam logic [31:0] LEG_IO_BASE0    = 32'h0000_03B0;
  localparam logic [31:0] LEG_IO_BASE1    = 32'h0000_03C0;
  localparam logic [31:0] LEG_IO_BASE2    = 32'h0000_03D0;
  localparam int          LEG_IO_LG2      = 4;
  localparam int          NWIN            = 9;

  // host apb register map
  localparam logic [11:0] REG_ADDR   = 12'h000;
  localparam logic [11:0] REG_CMD    = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam int CMD_SPACE_LSB = 0;
  localparam int CMD_WR_BIT    = 2;
  localparam int CMD_WDATA_LSB = 8;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_HIT_BIT     = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_RDATA_LSB   = 8;

  // address mask keeping bits at and above lg2
  function automatic logic [31:0] win_mask(input int lg2);
    win_mask = ~((32'h0000_0001 << lg2) - 32'h0000_0001);
  endfunction

  // bits of a configuration byte that are defined
  function automatic logic [7:0] cfg_defined(input logic [2:0] off);
    cfg_defined = (off == CFG_POS5) ? POS5_DEFINED : 8'hFF;
  endfunction
endpackage

// [core/iad_bus_if.sv]
`timescale 1ns/100ps
// system bus between host end and device end
interface iad_bus_if (
  input wire logic pclk,
  input wire logic presetn
);
  import iad_pkg::*;
  logic        req;     // request, held until ack seen
  iad_space_e  space;   // address space of the request
  logic [31:0] addr;    // byte address
  logic        wr;      // 1 write, 0 read
  logic [7:0]  wdata;   // write data
  logic        ack;     // one-cycle answer
  logic        hit;     // some window claimed the request
  logic [7:0]  rdata;   // read data, valid with ack

  modport dev (input pclk, presetn, req, space, addr, wr, wdata,
               output ack, hit, rdata);
  modport hst (input pclk, presetn, ack, hit, rdata,
               output req, space, addr, wr, wdata);
endinterface

// [core/iad_win_match.sv]
`timescale 1ns/100ps
// one address window: space, base and mask compare
module iad_win_match (
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  space,
  input  wire logic [1:0]  want_space,
  input  wire logic [31:0] base,
  input  wire logic [31:0] mask,
  input  wire logic        en,
  output logic             hit
);
  // only the masked upper bits take part, so base low bits are don't-care
  assign hit = en && (space == want_space) && ((addr & mask) == (base & mask));
endmodule

// [core/iad_dev_end.sv]
`timescale 1ns/100ps
// device end: configuration bytes plus address decode
module iad_dev_end (
  iad_bus_if.dev                bus,
  input  wire logic [15:0]      cfg_id,            // strap: subsystem identifier
  input  wire logic [7:0]       cfg_pos2,          // strap: rom, instance, enable
  input  wire logic [7:0]       cfg_pos4,          // strap: video base, enable
  input  wire logic [7:0]       cfg_pos5,          // strap: 1MB aperture
  input  wire logic             legacy_decode_en,  // from operating mode control
  input  wire iad_pkg::iad_mode_e display_mode,    // current display mode
  input  wire logic [7:0]       user_rdata,        // read data for bus.addr
  output logic                  dec_valid,         // one-cycle decoded access
  output iad_pkg::iad_target_e  dec_target,        // which window claimed it
  output logic [21:0]           dec_offset,        // offset inside window
  output logic                  dec_wr,            // decoded direction
  output logic [7:0]            dec_wdata,         // decoded write data
  output logic [2:0]            instance_select,   // instance of this unit
  output logic                  large_aperture_enable,
  output logic [3:0]            small_aperture_base,
  output logic                  subsys_en          // decoding enabled
);
  import iad_pkg::*;

  // bus handshake states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DROP = 1'b1
  } iad_dstate_e;

  iad_dstate_e  state;                    // handshake state
  logic         strap_done;               // straps captured
  logic [7:0]   id_low_byte;              // identifier low byte
  logic [7:0]   id_high_byte;             // identifier high byte
  logic [7:0]   rom_instance_enable_cfg;  // rom, instance, enable
  logic [7:0]   video_memory_base_cfg;    // video base, aperture enable
  logic [7:0]   small_aperture_cfg;       // 1MB aperture field
  logic [2:0]   isel;                     // instance field
  logic [3:0]   rom_sel;                  // rom block field
  logic         en;                       // subsystem enable
  logic         lae;                      // 4MB aperture enable
  logic [3:0]   sab;                      // 1MB aperture field
  logic         legacy_on;                // this unit owns legacy decode
  logic [31:0]  rom_block;                // base of the 8KB block
  logic [31:0]  win_base [NWIN];          // per-window base
  logic [31:0]  win_mask_a [NWIN];        // per-window mask
  logic [1:0]   win_space [NWIN];         // per-window space
  logic         win_en [NWIN];            // per-window enable
  logic         win_hit [NWIN];           // per-window match
  iad_target_e  win_tgt [NWIN];           // per-window target code
  iad_target_e  next_target;              // winning window
  logic [21:0]  next_offset;              // winning offset
  logic [7:0]   cfg_byte;                 // configuration read value
  logic         rom_area;                 // address inside the 7KB rom part

  // unpack the held configuration bytes
  assign rom_sel = rom_instance_enable_cfg[ROM_MSB:ROM_LSB];
  assign isel    = rom_instance_enable_cfg[ISEL_MSB:ISEL_LSB];
  assign en      = rom_instance_enable_cfg[EN_BIT];
  assign lae     = video_memory_base_cfg[LAE_BIT];
  assign sab     = small_aperture_cfg[SAB_MSB:SAB_LSB];

  // legacy decode only in legacy or 132-column text mode and when
  // this unit is the owner; the picture path does not look at this
  assign legacy_on = legacy_decode_en && (display_mode != DM_EXTENDED);

  // 8KB rom block selected by the rom field
  assign rom_block = ROM_REGION_BASE + ({28'h0, rom_sel} << ROM_BLOCK_LG2);
  // last 1KB belongs to coprocessor sections, never to the rom
  assign rom_area = (bus.addr[ROM_BLOCK_LG2-1:ROM_KB_LSB] != COP_KB_SLICE);

  // window table; every non-configuration window is gated by enable
  always_comb begin
    // io bank of 16 registers, one of eight sets by instance
    win_base[0]   = IO_BANK_BASE + ({29'h0, isel} << IO_BANK_LG2);
    win_mask_a[0] = win_mask(IO_BANK_LG2);
    win_space[0]  = SP_IO;
    win_en[0]     = en;
    win_tgt[0]    = TG_IOBANK;
    // rom, the first 7KB of the block
    win_base[1]   = rom_block;
    win_mask_a[1] = win_mask(ROM_BLOCK_LG2);
    win_space[1]  = SP_MEM;
    win_en[1]     = en && rom_area;
    win_tgt[1]    = TG_ROM;
    // coprocessor registers, instance picks the 128-byte section
    win_base[2]   = rom_block + COP_AREA_OFF + ({29'h0, isel} << COP_LG2);
    win_mask_a[2] = win_mask(COP_LG2);
    win_space[2]  = SP_MEM;
    win_en[2]     = en;
    win_tgt[2]    = TG_COP;
    // 4MB video aperture on base field plus instance
    win_base[3]   = {video_memory_base_cfg[VBASE_MSB:VBASE_LSB], isel, 22'h0};
    win_mask_a[3] = win_mask(VMEM_LG2);
    win_space[3]  = SP_MEM;
    win_en[3]     = en && lae;
    win_tgt[3]    = TG_VMEM;
    // 1MB aperture at n times 1MB, zero disables
    win_base[4]   = {8'h00, sab, 20'h0};
    win_mask_a[4] = win_mask(SMALL_LG2);
    win_space[4]  = SP_MEM;
    win_en[4]     = en && (sab != 4'h0);
    win_tgt[4]    = TG_SMALL;
    // legacy video memory
    win_base[5]   = LEG_MEM_BASE;
    win_mask_a[5] = win_mask(LEG_MEM_LG2);
    win_space[5]  = SP_MEM;
    win_en[5]     = en && legacy_on;
    win_tgt[5]    = TG_LEG_MEM;
    // legacy io, three 16-byte groups
    win_base[6]   = LEG_IO_BASE0;
    win_base[7]   = LEG_IO_BASE1;
    win_base[8]   = LEG_IO_BASE2;
    for (int i = 6; i < NWIN; i++) begin
      win_mask_a[i] = win_mask(LEG_IO_LG2);
      win_space[i]  = SP_IO;
      win_en[i]     = en && legacy_on;
      win_tgt[i]    = TG_LEG_IO;
    end
  end

  // one comparator per window
  generate
    for (genvar g = 0; g < NWIN; g++) begin : g_win
      iad_win_match u_match (
        .addr       (bus.addr),
        .space      (bus.space),
        .want_space (win_space[g]),
        .base       (win_base[g]),
        .mask       (win_mask_a[g]),
        .en         (win_en[g]),
        .hit        (win_hit[g])
      );
    end
  endgenerate

  // lowest-numbered window wins; windows should not overlap anyway
  always_comb begin
    next_target = TG_NONE;
    next_offset = 22'h0;
    for (int i = NWIN - 1; i >= 0; i--) begin
      if (win_hit[i]) begin
        next_target = win_tgt[i];
        next_offset = bus.addr[OFF_W-1:0] & ~win_mask_a[i][OFF_W-1:0];
      end
    end
  end

  // configuration read mux; holes and undefined bits read zero
  always_comb begin
    unique case (bus.addr[CFG_OFF_W-1:0])
      CFG_ID_LO: cfg_byte = id_low_byte;
      CFG_ID_HI: cfg_byte = id_high_byte;
      CFG_POS2:  cfg_byte = rom_instance_enable_cfg;
      CFG_POS4:  cfg_byte = video_memory_base_cfg;
      CFG_POS5:  cfg_byte = small_aperture_cfg & POS5_DEFINED;
      default:   cfg_byte = 8'h00;
    endcase
  end

  // straps are caught once after reset release; a reset cannot load a port
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      strap_done              <= 1'b0;
      id_low_byte             <= 8'h00;
      id_high_byte            <= 8'h00;
      rom_instance_enable_cfg <= 8'h00;
      video_memory_base_cfg   <= 8'h00;
      small_aperture_cfg      <= 8'h00;
    end else if (!strap_done) begin
      strap_done              <= 1'b1;
      id_low_byte             <= cfg_id[7:0];
      id_high_byte            <= cfg_id[15:8];
      rom_instance_enable_cfg <= cfg_pos2;
      video_memory_base_cfg   <= cfg_pos4;
      small_aperture_cfg      <= cfg_pos5;
    end
  end

  // mirror the live configuration to the display side
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      instance_select       <= 3'h0;
      large_aperture_enable <= 1'b0;
      small_aperture_base   <= 4'h0;
      subsys_en             <= 1'b0;
    end else begin
      instance_select       <= isel;
      large_aperture_enable <= lae;
      small_aperture_base   <= sab;
      subsys_en             <= en;
    end
  end

  // bus handshake: answer one cycle after the request is seen, then
  // wait for the request to fall so one request is never taken twice
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      state      <= ST_IDLE;
      bus.ack    <= 1'b0;
      bus.hit    <= 1'b0;
      bus.rdata  <= 8'h00;
      dec_valid  <= 1'b0;
      dec_target <= TG_NONE;
      dec_offset <= 22'h0;
      dec_wr     <= 1'b0;
      dec_wdata  <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (bus.req && strap_done) begin
            state   <= ST_DROP;
            bus.ack <= 1'b1;
            if (bus.space == SP_CFG) begin
              // configuration always answers; writes change nothing
              bus.hit   <= 1'b1;
              bus.rdata <= bus.wr ? 8'h00 : cfg_byte;
            end else begin
              // no window means no effect and no data
              bus.hit    <= (next_target != TG_NONE);
              bus.rdata  <= (!bus.wr && next_target != TG_NONE) ? user_rdata : 8'h00;
              dec_valid  <= (next_target != TG_NONE);
              dec_target <= next_target;
              dec_offset <= next_offset;
              dec_wr     <= bus.wr;
              dec_wdata  <= bus.wdata;
            end
          end
        end
        ST_DROP: begin
          bus.ack   <= 1'b0;
          dec_valid <= 1'b0;
          if (!bus.req) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// [core/iad_host_end.sv]
`timescale 1ns/100ps
// host end: apb command registers driving the system bus
module iad_host_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  iad_bus_if.hst           bus
);
  import iad_pkg::*;

  logic [31:0] addr_reg;     // target address
  logic        busy;         // bus request outstanding
  logic        last_hit;     // last request was claimed
  logic        refused;      // last command refused
  logic [7:0]  last_rdata;   // last read data, masked
  logic        setup;        // apb setup cycle
  logic        cmd_wr;       // apb write to command register
  logic [31:0] status_word;  // assembled status

  assign setup  = psel && !penable;
  assign cmd_wr = setup && pwrite && (paddr == REG_CMD);
  always_comb begin
    status_word = 32'h0;
    status_word[ST_BUSY_BIT]    = busy;
    status_word[ST_HIT_BIT]     = last_hit;
    status_word[ST_REFUSED_BIT] = refused;
    status_word[ST_RDATA_LSB +: DATA_W] = last_rdata;
  end

  // apb slave: decode in setup, answer in the access cycle, no waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      addr_reg <= 32'h0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !(paddr == REG_ADDR || paddr == REG_CMD || paddr == REG_STATUS);
        unique case (paddr)
          REG_ADDR:   prdata <= addr_reg;
          REG_STATUS: prdata <= status_word;
          default:    prdata <= 32'h0;
        endcase
        if (pwrite && paddr == REG_ADDR) begin
          addr_reg <= pwdata;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // bus master: a command starts one request, held until ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      last_hit   <= 1'b0;
      refused    <= 1'b0;
      last_rdata <= 8'h00;
      bus.req    <= 1'b0;
      bus.space  <= SP_CFG;
      bus.addr   <= 32'h0;
      bus.wr     <= 1'b0;
      bus.wdata  <= 8'h00;
    end else if (busy) begin
      if (bus.ack) begin
        busy       <= 1'b0;
        bus.req    <= 1'b0;
        last_hit   <= bus.hit;
        // undefined configuration bits are masked before software tests them
        last_rdata <= (bus.space == SP_CFG) ?
                      (bus.rdata & cfg_defined(bus.addr[CFG_OFF_W-1:0])) : bus.rdata;
      end
    end else if (cmd_wr) begin
      // configuration writes are never issued
      if (iad_space_e'(pwdata[CMD_SPACE_LSB +: 2]) == SP_CFG && pwdata[CMD_WR_BIT]) begin
        refused <= 1'b1;
      end else begin
        refused   <= 1'b0;
        busy      <= 1'b1;
        bus.req   <= 1'b1;
        bus.space <= iad_space_e'(pwdata[CMD_SPACE_LSB +: 2]);
        bus.addr  <= addr_reg;
        bus.wr    <= pwdata[CMD_WR_BIT];
        bus.wdata <= pwdata[CMD_WDATA_LSB +: DATA_W];
      end
    end
  end
endmodule

// [tb/iad_bus_assertions.sv]
`timescale 1ns/100ps
// watches the system bus that joins the host end to the device end
module iad_bus_assertions (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               req,
  input wire iad_pkg::iad_space_e space,
  input wire logic [31:0]        addr,
  input wire logic               wr,
  input wire logic [7:0]         wdata,
  input wire logic               ack,
  input wire logic               hit,
  input wire logic [7:0]         rdata
);
  import iad_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer to a configuration read
  wire cfg_ack = ack && (space == SP_CFG);

  a_ack_after_req: assert property ($rose(req) |=> ack)
    else $error("no answer one cycle after request");
  a_ack_needs_req: assert property (ack |-> req)
    else $error("answer without a request");
  // one answer per request, no second take while req drains
  a_single_take: assert property (ack |=> !ack [*2])
    else $error("answer longer than one cycle");
  a_req_held: assert property (req && !ack |=> req && $stable({space, addr, wr, wdata}))
    else $error("request changed before its answer");
  a_cfg_no_write: assert property (req && space == SP_CFG |-> !wr)
    else $error("write sent to configuration space");
  a_cfg_always_hit: assert property (cfg_ack |-> hit)
    else $error("configuration read not claimed");
  a_cfg_gap_zero: assert property (cfg_ack && addr[2:0] inside {3'h3, 3'h6, 3'h7} |-> rdata == 8'h00)
    else $error("unused configuration byte not zero");
  a_undef_masked: assert property (cfg_ack && addr[2:0] == CFG_POS5 |-> rdata[7:4] == 4'h0)
    else $error("undefined aperture bits not zero");
  // result holds between answers so the host may read it late
  a_answer_holds: assert property (!ack |-> $stable({hit, rdata}))
    else $error("answer changed without an ack");

  c_cfg_read: cover property (cfg_ack);
  c_mem_hit: cover property (ack && hit && space == SP_MEM);
  c_miss: cover property (ack && !hit);
endmodule

// [tb/instance_address_decode_tb.sv]
`timescale 1ns/100ps
// drives apb and straps, judges status bytes and decode outputs
module instance_address_decode_tb;
  import iad_pkg::*;
  localparam logic [15:0] SUB_ID = 16'h5AC3; // arbitrary identifier
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        legacy_decode_en, dec_valid, dec_wr, large_aperture_enable, subsys_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pos2, pos4, pos5, user_rdata, dec_wdata;
  logic [21:0] dec_offset;
  logic [2:0]  instance_select;
  logic [3:0]  small_aperture_base;
  iad_mode_e   display_mode;
  iad_target_e dec_target;
  int          n_mismatch, num_checks, npulse, cyc;

  iad_bus_if iad_bus_if_i (.pclk(pclk), .presetn(presetn));
  iad_host_end iad_host_end_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(iad_bus_if_i));
  iad_dev_end iad_dev_end_i (.bus(iad_bus_if_i), .cfg_id(SUB_ID), .cfg_pos2(pos2),
    .cfg_pos4(pos4), .cfg_pos5(pos5), .legacy_decode_en(legacy_decode_en),
    .display_mode(display_mode), .user_rdata(user_rdata), .dec_valid(dec_valid),
    .dec_target(dec_target), .dec_offset(dec_offset), .dec_wr(dec_wr),
    .dec_wdata(dec_wdata), .instance_select(instance_select),
    .large_aperture_enable(large_aperture_enable),
    .small_aperture_base(small_aperture_base), .subsys_en(subsys_en));
  iad_bus_assertions iad_bus_assertions_i (.pclk(pclk), .presetn(presetn),
    .req(iad_bus_if_i.req), .space(iad_bus_if_i.space), .addr(iad_bus_if_i.addr),
    .wr(iad_bus_if_i.wr), .wdata(iad_bus_if_i.wdata), .ack(iad_bus_if_i.ack),
    .hit(iad_bus_if_i.hit), .rdata(iad_bus_if_i.rdata));

  always #12.5 pclk = ~pclk;
  // counts decode pulses; a hang is cut short here
  always @(posedge pclk) begin
    if (dec_valid === 1'b1) npulse++;
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      results;
    end
  end

  task ck(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // straps only load after reset, so new values need a new reset
  task rst(input logic [7:0] p2, p4, p5);
    presetn <= 0; pos2 <= p2; pos4 <= p4; pos5 <= p5;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
  endtask
  // one system bus access, polled until the host end is idle
  task op(input logic [1:0] sp, input logic [31:0] a, input logic w, output logic [31:0] st);
    logic e;
    apb(1, REG_ADDR, a, st, e);
    apb(1, REG_CMD, {16'h0, 8'h96, 5'h0, w, sp}, st, e);
    st = 32'h1;
    while (st[ST_BUSY_BIT] !== 1'b0) apb(0, REG_STATUS, 32'h0, st, e);
  endtask
  task chk(input logic [1:0] sp, input logic [31:0] a, input logic w, eh,
           input iad_target_e tg, input logic [21:0] of);
    int n0;
    logic [31:0] st;
    n0 = npulse;
    op(sp, a, w, st);
    ck(st[ST_HIT_BIT] === eh && npulse == n0 + int'(eh), "hit or pulse");
    if (eh) ck(dec_target === tg && dec_offset === of && dec_wr === w, "decode");
    if (eh && w) ck(dec_wdata === 8'h96, "write data");
    if (eh && !w) ck(st[15:8] === 8'h5C, "read data");
  endtask

  task t_cfg;
    logic [7:0] x [8];
    logic [31:0] st;
    logic e;
    x = '{SUB_ID[7:0], SUB_ID[15:8], 8'h35, 8'h00, 8'h03, 8'h07, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      op(SP_CFG, i, 1'b0, st);
      ck(st[ST_HIT_BIT] === 1'b1 && st[15:8] === x[i], "config byte");
    end
    op(SP_CFG, 32'h2, 1'b1, st);
    ck(st[ST_REFUSED_BIT] === 1'b1, "config write");
    apb(0, 12'h00C, 32'h0, st, e);
    ck(e === 1'b1, "unmapped");
    ck(instance_select === 3'h2 && subsys_en === 1'b1 && large_aperture_enable === 1'b1
       && small_aperture_base === 4'h7, "mirror");
    $display("config test done");
  endtask
  task t_win;
    chk(SP_IO, 32'h2125, 0, 1, TG_IOBANK, 22'h5);
    chk(SP_IO, 32'h2115, 0, 0, TG_NONE, 22'h0);
    chk(SP_MEM, 32'hC6010, 0, 1, TG_ROM, 22'h10);
    chk(SP_MEM, 32'hC7D04, 1, 1, TG_COP, 22'h4);
    chk(SP_MEM, 32'hC7C04, 0, 0, TG_NONE, 22'h0);
    chk(SP_MEM, 32'h0280_0123, 1, 1, TG_VMEM, 22'h123);
    chk(SP_MEM, 32'h0380_0123, 0, 0, TG_NONE, 22'h0);
    chk(SP_MEM, 32'h0070_0055, 0, 1, TG_SMALL, 22'h55);
    chk(SP_MEM, 32'h000A_0010, 0, 1, TG_LEG_MEM, 22'h10);
    chk(SP_IO, 32'h3D4, 0, 1, TG_LEG_IO, 22'h4);
    $display("window test done");
  endtask
  task t_mode;
    display_mode <= DM_TEXT132;
    chk(SP_MEM, 32'h000A_0010, 0, 1, TG_LEG_MEM, 22'h10);
    display_mode <= DM_EXTENDED;
    chk(SP_MEM, 32'h000A_0010, 0, 0, TG_NONE, 22'h0);
    display_mode <= DM_LEGACY;
    // legacy sharing goes through the owner input, never the subsystem enable
    legacy_decode_en <= 0;
    chk(SP_IO, 32'h3D4, 0, 0, TG_NONE, 22'h0);
    chk(SP_MEM, 32'h0280_0010, 0, 1, TG_VMEM, 22'h10);
    legacy_decode_en <= 1;
    $display("mode test done");
  endtask
  task t_dis;
    logic [31:0] st;
    int n0;
    rst(8'h34, 8'h02, 8'h00);
    n0 = npulse;
    op(SP_IO, 32'h2125, 1'b0, st);
    ck(st[ST_HIT_BIT] === 1'b0 && st[15:8] === 8'h00 && npulse == n0, "disabled");
    op(SP_CFG, 32'h2, 1'b0, st);
    ck(st[15:8] === 8'h34 && subsys_en === 1'b0, "config while off");
    ck(large_aperture_enable === 1'b0 && small_aperture_base === 4'h0, "mirror");
    rst(8'h35, 8'h02, 8'h00);
    chk(SP_MEM, 32'h0280_0123, 0, 0, TG_NONE, 22'h0);
    chk(SP_MEM, 32'h0000_0055, 0, 0, TG_NONE, 22'h0);
    $display("disable test done");
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; user_rdata = 8'h5C;
    legacy_decode_en = 1; display_mode = DM_LEGACY;
    pos2 = 8'h35; pos4 = 8'h03; pos5 = 8'hA7;
    n_mismatch = 0; num_checks = 0; npulse = 0; cyc = 0;
    rst(8'h35, 8'h03, 8'hA7);
    t_cfg;
    t_win;
    t_mode;
    t_dis;
    results;
  end
endmodule
